// >>> core/ain_conv_seq.sv
/*
  Conversion sequencer: walks the enabled channels round robin, runs one
  conversion each and offers the result on a valid/ready port.
  Assumes: the front end answers convStart with a one-cycle convDone on clk_sys.
*/
module ain_conv_seq (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // per-channel conversion enable
  input wire logic [ain_pkg::CH_COUNT-1:0] convEnable,
  // converter front end
  output logic convStart_q,
  output logic [ain_pkg::CH_W-1:0] convChan_q,
  input wire logic convDone,
  input wire logic [ain_pkg::DATA_W-1:0] convRaw,
  input wire logic convBreak,
  // results
  sample_if.src outPort
);
  typedef enum logic [1:0] {IDLE, START, WAIT, PUSH} seq_state_t;
  seq_state_t state_q;
  logic [ain_pkg::DATA_W-1:0] raw_q;
  logic brk_q;
  logic found;
  logic [ain_pkg::CH_W-1:0] nextChan;

  // first enabled channel after the current one; disabled ones cost no time
  always_comb begin
    logic [ain_pkg::CH_W-1:0] cand;
    cand = '0;
    found = 1'b0;
    nextChan = convChan_q;
    for (int i = 1; i <= ain_pkg::CH_COUNT; i++) begin
      cand = convChan_q + ain_pkg::CH_W'(i);
      if (!found && convEnable[cand]) begin
        found = 1'b1;
        nextChan = cand;
      end
    end
  end

  assign outPort.valid = (state_q == PUSH);
  assign outPort.data = '{chan: convChan_q, raw: raw_q, brk: brk_q};

  // one conversion at a time, held until the buffer takes it
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      state_q <= IDLE;
      convStart_q <= 1'b0;
      convChan_q <= '1;
      raw_q <= '0;
      brk_q <= 1'b0;
    end else begin
      convStart_q <= 1'b0;
      unique case (state_q)
        IDLE: begin
          if (found) begin
            convChan_q <= nextChan;
            state_q <= START;
          end
        end
        START: begin
          convStart_q <= 1'b1;
          state_q <= WAIT;
        end
        WAIT: begin
          if (convDone) begin
            raw_q <= convRaw;
            brk_q <= convBreak;
            state_q <= PUSH;
          end
        end
        PUSH: begin
          if (outPort.ready) begin
            state_q <= IDLE;
          end
        end
      endcase
    end
  end
endmodule // ain_conv_seq

// >>> core/ain_sample_fifo.sv
/*
  Small flip-flop FIFO in the sample path; stalls the sequencer when full.
  Assumes: DEPTH of at least two, same clock on both sides.
*/
module ain_sample_fifo #(
  parameter int DEPTH = ain_pkg::FIFO_DEPTH,
  parameter int W = $bits(ain_pkg::sample_t)
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // filling and draining sides
  sample_if.dst inPort,
  sample_if.src outPort
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL = (PW+1)'(DEPTH);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);

  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] wrPtr_q;
  logic [PW-1:0] rdPtr_q;
  logic [PW:0] count_q;
  logic push;
  logic pop;

  // honest full and empty from the fill count
  assign inPort.ready = (count_q != FULL);
  assign outPort.valid = (count_q != '0);
  assign outPort.data = mem[rdPtr_q];
  assign push = inPort.valid && inPort.ready;
  assign pop = outPort.valid && outPort.ready;

  // storage, written only on a push
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem[wrPtr_q] <= inPort.data;
    end
  end

  // pointers wrap at DEPTH, which need not be a power of two
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) begin
        wrPtr_q <= (wrPtr_q == LAST) ? '0 : wrPtr_q + 1'b1;
      end
      if (pop) begin
        rdPtr_q <= (rdPtr_q == LAST) ? '0 : rdPtr_q + 1'b1;
      end
      if (push && !pop) begin
        count_q <= count_q + 1'b1;
      end else if (pop && !push) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule // ain_sample_fifo

// >>> core/ain_scan_top.sv
/*
  Readout and status logic of an eight-channel analog input module: scan
  words, config data memory, limit flags, indicators, AXI4-Lite slave.
  Assumes: front end on clk_sys gives offset-binary 16-bit results; the
  rear switches are asynchronous pins.
*/
//////////////////////////////////////////////////////////////////////////////
module ain_scan_top #(
  parameter int BLINK_CYCLES = ain_pkg::BLINK_HALF_CYC,
  parameter int CNT_W = 24
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // axi4-lite write
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // converter front end
  output logic convStart,
  output logic [ain_pkg::CH_W-1:0] convChan,
  input wire logic convDone,
  input wire logic [ain_pkg::DATA_W-1:0] convRaw,
  input wire logic convBreak,
  // rear switches
  input wire logic [2:0] rangeSwitch,
  input wire logic formatSelectSwitch,
  // indicators
  output logic [ain_pkg::CH_COUNT-1:0] channelIndicators,
  output logic activityIndicator
);
  localparam int CH = ain_pkg::CH_COUNT;
  localparam int DW = ain_pkg::DATA_W;
  localparam logic [CNT_W-1:0] BLINK_LAST = CNT_W'(BLINK_CYCLES - 1);

  //////////////////////////////////////////////////////////////////////////
  // rear switch synchronisers
  logic [3:0] sw1_q;
  logic [3:0] sw2_q;
  logic [3:0] sw3_q;
  logic [3:0] swStable_q;
  logic [2:0] rangeCode;
  logic fmtSigned;
  logic rangeOk;
  logic lbAllowed;

  // a change counts only once the second and third stage agree
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      sw1_q <= '0;
      sw2_q <= '0;
      sw3_q <= '0;
      swStable_q <= '0;
    end else begin
      sw1_q <= {rangeSwitch, formatSelectSwitch};
      sw2_q <= sw1_q;
      sw3_q <= sw2_q;
      if (sw2_q == sw3_q) begin
        swStable_q <= sw3_q;
      end
    end
  end

  // one range and one format for every channel
  assign rangeCode = swStable_q[3:1];
  assign fmtSigned = swStable_q[0];
  assign lbAllowed = (rangeCode == ain_pkg::RANGE_V1_5) ||
                     (rangeCode == ain_pkg::RANGE_I4_20);
  assign rangeOk = lbAllowed || (rangeCode == ain_pkg::RANGE_V0_10) ||
                   (rangeCode == ain_pkg::RANGE_V_BIP) ||
                   (rangeCode == ain_pkg::RANGE_I0_20) ||
                   (rangeCode == ain_pkg::RANGE_I_BIP);

  //////////////////////////////////////////////////////////////////////////
  // axi4-lite write channel
  logic awHeld_q;
  logic wHeld_q;
  logic awHeldD;
  logic wHeldD;
  logic [5:0] wrWord_q;
  logic [31:0] wrData_q;
  logic [3:0] wrStrb_q;
  logic doWrite;
  logic wrScan;
  logic wrCdm;
  logic [5:0] wrIdx;

  // address and data are taken in either order, the write once both stand
  assign doWrite = awHeld_q && wHeld_q && !bvalid;
  assign awHeldD = (awHeld_q && !doWrite) || (awvalid && awready);
  assign wHeldD = (wHeld_q && !doWrite) || (wvalid && wready);
  assign wrIdx = wrWord_q - ain_pkg::WORD_CDM_BASE;
  assign wrScan = (wrWord_q < ain_pkg::WORD_SCAN_END);
  assign wrCdm = (wrWord_q >= ain_pkg::WORD_CDM_BASE) &&
                 (wrIdx < ain_pkg::CDM_END);

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      wrWord_q <= '0;
      wrData_q <= '0;
      wrStrb_q <= '0;
    end else begin
      awHeld_q <= awHeldD;
      wHeld_q <= wHeldD;
      awready <= !awHeldD;
      wready <= !wHeldD;
      if (awvalid && awready) begin
        wrWord_q <= awaddr[7:2];
      end
      if (wvalid && wready) begin
        wrData_q <= wdata;
        wrStrb_q <= wstrb;
      end
    end
  end

  // scan words are read only; unmapped words outside the config data memory also answer slverr
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      bvalid <= 1'b0;
      bresp <= ain_pkg::RESP_OKAY;
    end else if (doWrite) begin
      bvalid <= 1'b1;
      bresp <= (wrCdm && !wrScan) ? ain_pkg::RESP_OKAY
                                  : ain_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // config data memory
  logic [15:0] limCtrl_q;
  logic [CH-1:0] convDis_q;
  logic [CH-1:0] dataType_q;
  logic [DW-1:0] lowLim_q [CH];
  logic [DW-1:0] highLim_q [CH];
  logic [DW-1:0] engMin_q [CH];
  logic [DW-1:0] engMax_q [CH];
  logic [5:0] limOff;
  logic [5:0] engOff;

  assign limOff = wrIdx - ain_pkg::CDM_LIMIT_BASE;
  assign engOff = wrIdx - ain_pkg::CDM_ENG_BASE;

  // byte strobes apply to the low half word
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0] s);
    logic [15:0] r;
    r = old;
    if (s[0]) begin
      r[7:0] = d[7:0];
    end
    if (s[1]) begin
      r[15:8] = d[15:8];
    end
    return r;
  endfunction

  // defaults: all converting, no limit checks, raw data
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      limCtrl_q <= '0;
      convDis_q <= '0;
      dataType_q <= '0;
      for (int i = 0; i < CH; i++) begin
        lowLim_q[i] <= '0;
        highLim_q[i] <= '0;
        engMin_q[i] <= '0;
        engMax_q[i] <= '0;
      end
    end else if (doWrite && wrCdm) begin
      if (wrIdx == ain_pkg::CDM_LIM_CTRL) begin
        limCtrl_q <= merge(limCtrl_q, wrData_q, wrStrb_q);
      end else if (wrIdx == ain_pkg::CDM_CONV_DIS) begin
        if (wrStrb_q[0]) begin
          convDis_q <= wrData_q[CH-1:0];
        end
      end else if (wrIdx == ain_pkg::CDM_DATA_TYPE) begin
        if (wrStrb_q[1]) begin
          dataType_q <= wrData_q[ain_pkg::DTYPE_LSB +: CH];
        end
      end else if (wrIdx >= ain_pkg::CDM_ENG_BASE) begin
        if (engOff[0]) begin
          engMax_q[engOff[3:1]] <= merge(engMax_q[engOff[3:1]], wrData_q,
                                         wrStrb_q);
        end else begin
          engMin_q[engOff[3:1]] <= merge(engMin_q[engOff[3:1]], wrData_q,
                                         wrStrb_q);
        end
      end else if (wrIdx >= ain_pkg::CDM_LIMIT_BASE) begin
        if (limOff[0]) begin
          highLim_q[limOff[3:1]] <= merge(highLim_q[limOff[3:1]], wrData_q,
                                          wrStrb_q);
        end else begin
          lowLim_q[limOff[3:1]] <= merge(lowLim_q[limOff[3:1]], wrData_q,
                                         wrStrb_q);
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // sequencer and sample buffer
  sample_if seqLink ();
  sample_if bufLink ();

  ain_conv_seq u_seq (
    .clk_sys(clk_sys),
    .srst(srst),
    .convEnable(~convDis_q),
    .convStart_q(convStart),
    .convChan_q(convChan),
    .convDone(convDone),
    .convRaw(convRaw),
    .convBreak(convBreak),
    .outPort(seqLink)
  );

  ain_sample_fifo u_fifo (
    .clk_sys(clk_sys),
    .srst(srst),
    .inPort(seqLink),
    .outPort(bufLink)
  );

  //////////////////////////////////////////////////////////////////////////
  // sample formatting, scaling and limit test
  logic [DW-1:0] chVal_q [CH];
  logic [CH-1:0] brkFlag_q;
  logic [CH-1:0] lowFlag_q;
  logic [CH-1:0] highFlag_q;
  logic pop;
  logic [ain_pkg::CH_W-1:0] sCh;
  logic [DW-1:0] rawFmt;
  logic signed [16:0] span;
  logic signed [33:0] prod;
  logic [DW-1:0] scaled;
  logic [DW-1:0] value;
  logic signedCmp;
  logic lowHit;
  logic highHit;

  // a config write stalls the drain, so no sample is taken in the cycle a config word is written
  assign bufLink.ready = !doWrite;
  assign pop = bufLink.valid && bufLink.ready;
  assign sCh = bufLink.data.chan;

  always_comb begin
    // front end delivers offset binary; flip msb for two's complement
    rawFmt = fmtSigned ? (bufLink.data.raw ^ ain_pkg::SIGN_FLIP)
                       : bufLink.data.raw;
    span = $signed({engMax_q[sCh][DW-1], engMax_q[sCh]}) -
           $signed({engMin_q[sCh][DW-1], engMin_q[sCh]});
    prod = span * $signed({1'b0, bufLink.data.raw});
    scaled = engMin_q[sCh] + prod[31:16];
    value = dataType_q[sCh] ? scaled : rawFmt;
    signedCmp = dataType_q[sCh] || fmtSigned;
    if (signedCmp) begin
      lowHit = $signed(value) <= $signed(lowLim_q[sCh]);
      highHit = $signed(value) >= $signed(highLim_q[sCh]);
    end else begin
      lowHit = value <= lowLim_q[sCh];
      highHit = value >= highLim_q[sCh];
    end
  end

  // only converted channels update; the rest keep their last value
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      brkFlag_q <= '0;
      lowFlag_q <= '0;
      highFlag_q <= '0;
      for (int i = 0; i < CH; i++) begin
        chVal_q[i] <= '0;
      end
    end else if (pop) begin
      chVal_q[sCh] <= value;
      brkFlag_q[sCh] <= bufLink.data.brk;
      lowFlag_q[sCh] <= lowHit;
      highFlag_q[sCh] <= highHit;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // per-channel status gating and configuration checks
  logic [CH-1:0] lowEn;
  logic [CH-1:0] highEn;
  logic [CH-1:0] brkShown;
  logic [CH-1:0] lowShown;
  logic [CH-1:0] highShown;
  logic [CH-1:0] engBad;

  for (genvar g = 0; g < CH; g++) begin : g_chan
    assign lowEn[g] = limCtrl_q[2*g];
    assign highEn[g] = limCtrl_q[2*g+1];
    assign brkShown[g] = brkFlag_q[g] && lbAllowed;
    assign lowShown[g] = lowFlag_q[g] && lowEn[g];
    assign highShown[g] = highFlag_q[g] && highEn[g];
    // a scaled channel with an empty or inverted span cannot be scaled
    assign engBad[g] = dataType_q[g] &&
                       ($signed(engMin_q[g]) >= $signed(engMax_q[g]));
  end

  //////////////////////////////////////////////////////////////////////////
  // axi4-lite read channel
  logic [5:0] arWord;
  logic [5:0] rdIdx;
  logic [5:0] rdOff;
  logic [15:0] rdWord;
  logic rdErr;
  logic rvalidD;

  assign arWord = araddr[7:2];
  assign rdIdx = arWord - ain_pkg::WORD_CDM_BASE;
  assign rvalidD = (arvalid && arready) || (rvalid && !rready);

  // two status words, then the eight channel words
  always_comb begin
    rdWord = '0;
    rdErr = 1'b0;
    rdOff = '0;
    if (arWord == ain_pkg::WORD_BRK) begin
      rdWord = {8'h00, brkShown};
    end else if (arWord == ain_pkg::WORD_LIM) begin
      rdWord = {highShown, lowShown};
    end else if (arWord < ain_pkg::WORD_SCAN_END) begin
      rdOff = arWord - ain_pkg::WORD_CH0;
      rdWord = chVal_q[rdOff[2:0]];
    end else if (arWord >= ain_pkg::WORD_CDM_BASE &&
                 rdIdx < ain_pkg::CDM_END) begin
      if (rdIdx == ain_pkg::CDM_LIM_CTRL) begin
        rdWord = limCtrl_q;
      end else if (rdIdx == ain_pkg::CDM_CONV_DIS) begin
        rdWord = {8'h00, convDis_q};
      end else if (rdIdx == ain_pkg::CDM_DATA_TYPE) begin
        rdWord = {dataType_q, 8'h00};
      end else if (rdIdx >= ain_pkg::CDM_ENG_BASE) begin
        rdOff = rdIdx - ain_pkg::CDM_ENG_BASE;
        rdWord = rdOff[0] ? engMax_q[rdOff[3:1]] : engMin_q[rdOff[3:1]];
      end else if (rdIdx >= ain_pkg::CDM_LIMIT_BASE) begin
        rdOff = rdIdx - ain_pkg::CDM_LIMIT_BASE;
        rdWord = rdOff[0] ? highLim_q[rdOff[3:1]] : lowLim_q[rdOff[3:1]];
      end
    end else begin
      rdErr = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= ain_pkg::RESP_OKAY;
    end else begin
      arready <= !rvalidD;
      rvalid <= rvalidD;
      if (arvalid && arready) begin
        rdata <= {16'h0000, rdWord};
        rresp <= rdErr ? ain_pkg::RESP_SLVERR : ain_pkg::RESP_OKAY;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // indicators
  logic cfgErr_q;
  logic [CNT_W-1:0] blinkCnt_q;
  logic blink_q;

  // limit indicators follow the enabled, reached flags
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      channelIndicators <= '0;
    end else begin
      channelIndicators <= lowShown | highShown;
    end
  end

  // an illegal switch code or a bad scaling span is a config error
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cfgErr_q <= 1'b0;
    end else begin
      cfgErr_q <= !rangeOk || (|engBad);
    end
  end

  // free-running slow blink; only shown while the error stands
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      blinkCnt_q <= '0;
      blink_q <= 1'b0;
    end else if (blinkCnt_q == BLINK_LAST) begin
      blinkCnt_q <= '0;
      blink_q <= !blink_q;
    end else begin
      blinkCnt_q <= blinkCnt_q + 1'b1;
    end
  end

  // steady on in normal operation
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      activityIndicator <= 1'b0;
    end else begin
      activityIndicator <= cfgErr_q ? blink_q : 1'b1;
    end
  end
endmodule // ain_scan_top

// >>> include/ain_pkg.sv
/*
  Shared constants and types of the eight-channel analog input scan block.
  Assumes: 25 MHz system clock, AXI4-Lite register access, 16-bit results.
*/
package ain_pkg;
  localparam int CH_COUNT = 8;
  localparam int DATA_W = 16;
  localparam int CH_W = 3;
  localparam int FIFO_DEPTH = 2;

  // word index = byte address bits [7:2]
  localparam logic [5:0] WORD_BRK = 6'h00;
  localparam logic [5:0] WORD_LIM = 6'h01;
  localparam logic [5:0] WORD_CH0 = 6'h02;
  localparam logic [5:0] WORD_SCAN_END = 6'h0A;
  localparam logic [5:0] WORD_CDM_BASE = 6'h10;

  // config data memory word indices
  localparam logic [5:0] CDM_LIM_CTRL = 6'h01;
  localparam logic [5:0] CDM_CONV_DIS = 6'h02;
  localparam logic [5:0] CDM_LIMIT_BASE = 6'h03;
  localparam logic [5:0] CDM_DATA_TYPE = 6'h13;
  localparam logic [5:0] CDM_ENG_BASE = 6'h14;
  localparam logic [5:0] CDM_END = 6'h24;
  localparam int DTYPE_LSB = 8;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // range switch code {sw1, sw2, sw3}
  localparam logic [2:0] RANGE_V0_10 = 3'h0;
  localparam logic [2:0] RANGE_V1_5 = 3'h2;
  localparam logic [2:0] RANGE_V_BIP = 3'h1;
  localparam logic [2:0] RANGE_I0_20 = 3'h4;
  localparam logic [2:0] RANGE_I4_20 = 3'h6;
  localparam logic [2:0] RANGE_I_BIP = 3'h5;

  localparam logic [15:0] SIGN_FLIP = 16'h8000;

  // slow blink half period of the activity indicator
  localparam int BLINK_HALF_MS = 500;
  localparam int CLK_KHZ = 25000;
  localparam int BLINK_HALF_CYC = BLINK_HALF_MS * CLK_KHZ;

  typedef struct packed {
    logic [CH_W-1:0] chan;
    logic [DATA_W-1:0] raw;
    logic brk;
  } sample_t;
endpackage

// >>> include/sample_if.sv
/*
  Valid/ready carrier for one converted sample between the block's modules.
  Assumes: a single clock domain; data stands while valid waits for ready.
*/
interface sample_if;
  logic valid;
  logic ready;
  ain_pkg::sample_t data;
  modport src(output valid, output data, input ready);
  modport dst(input valid, input data, output ready);
endinterface

// >>> test/ain_front_model.sv
/*
  Behavioural converter front end: answers each start after a delay.
  Assumes: same clock as the block; high channels answer more slowly.
*/
module ain_front_model (
  // clock
  input wire logic clk_sys,
  // conversion handshake
  input wire logic convStart,
  input wire logic [2:0] convChan,
  output logic convDone,
  output logic [15:0] convRaw,
  output logic convBreak
);
  timeunit 1ns;
  timeprecision 1ps;
  // one driver per line: results stay unknown until the first done pulse
  int cnt = 0;
  logic [2:0] chan;
  //////////////////////////////////////////////////////////////////////////
  // result lines toggle outside the done pulse so stale data never passes
  always @(posedge clk_sys) begin
    convDone <= 1'b0;
    convRaw <= ~convRaw;
    convBreak <= ~convBreak;
    if (convStart) begin
      chan <= convChan;
      cnt <= 3 + int'(convChan);
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      if (cnt == 1) begin
        convDone <= 1'b1;
        convRaw <= {1'b0, chan, 12'h000} + 16'h1000;
        convBreak <= chan[0]; // odd channels report a broken wire
      end
    end
  end
endmodule // ain_front_model

// >>> test/ain_scan_sva.sv
/*
  Port-level checker of the analog input scan block.
  Assumes: single clock, srst synchronous; bound to every top instance.
*/
module ain_scan_sva (
  // clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // register bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  // front end, switches, indicators
  input wire logic convStart,
  input wire logic [2:0] rangeSwitch,
  input wire logic activityIndicator
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  logic [7:0] rdAddr_q;
  //////////////////////////////////////////////////////////////////////////
  // remember the read address so the answer can be judged by its word
  always_ff @(posedge clk_sys) begin
    if (arvalid && arready) rdAddr_q <= araddr;
  end
  a_read_lat: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  a_read_hold: assert property (rvalid && !rready |=>
    rvalid && $stable(rdata))
    else $error("read data moved");
  a_word_width: assert property (rvalid |-> rdata[31:16] == 16'h0)
    else $error("upper read bits set");
  a_write_lat: assert property (awvalid && awready && wvalid && wready
    |-> ##2 bvalid)
    else $error("write answer late");
  a_resp_hold: assert property (bvalid && !bready |=>
    bvalid && $stable(bresp))
    else $error("write response moved");
  a_start_pulse: assert property (convStart |=> !convStart)
    else $error("start pulse too long");
  // the switch synchroniser needs a few edges, so require a long-held code
  a_break_range: assert property (rvalid && rdAddr_q == 8'h00
    && rangeSwitch == ain_pkg::RANGE_V0_10
    && $past(rangeSwitch, 8) == ain_pkg::RANGE_V0_10
    |-> rdata[7:0] == 8'h00)
    else $error("break flag outside range");
  a_steady_act: assert property (!$past(srst) && rangeSwitch == 3'h0
    && $past(rangeSwitch, 8) == 3'h0 |-> activityIndicator)
    else $error("activity indicator not steady");
endmodule // ain_scan_sva

bind ain_scan_top ain_scan_sva chk (.clk_sys, .srst, .awvalid, .awready,
  .wvalid, .wready, .bvalid, .bready, .bresp, .araddr, .arvalid, .arready,
  .rvalid, .rready, .rdata, .convStart, .rangeSwitch, .activityIndicator);

// >>> test/eight_channel_analog_input_scan_bench.sv
/*
  Self-checking bench of the analog input scan block.
  Assumes: front end model on the converter port; bus tasks on AXI4-Lite.
*/
module eight_channel_analog_input_scan_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys = 0, srst = 1;
  logic [7:0] awaddr = 0, araddr = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0, rdata;
  logic [1:0] bresp, rresp, resp;
  logic awready, wready, bvalid, arready, rvalid;
  logic convStart, convDone, convBreak, activityIndicator;
  logic [2:0] convChan, rangeSwitch = 0;
  logic formatSelectSwitch = 0;
  logic [15:0] convRaw;
  logic [7:0] channelIndicators;
  int errorCnt = 0, compares = 0;
  always #20 clk_sys = ~clk_sys;
  ain_scan_top #(.BLINK_CYCLES(8)) uut (.clk_sys, .srst, .awaddr, .awvalid,
    .awready, .wdata, .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .convStart, .convChan, .convDone, .convRaw, .convBreak, .rangeSwitch,
    .formatSelectSwitch, .channelIndicators, .activityIndicator);
  ain_front_model fe (.clk_sys, .convStart, .convChan, .convDone, .convRaw,
    .convBreak);
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) begin
      errorCnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk_sys);
    {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
    while (awvalid || wvalid) begin
      @(posedge clk_sys);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
    end
    do @(posedge clk_sys); while (!bvalid);
    resp = bresp;
    bready <= 0;
  endtask
  task automatic rdc(string nm, logic [7:0] a, logic [31:0] e);
    @(posedge clk_sys);
    {araddr, arvalid, rready} <= {a, 2'b11};
    do @(posedge clk_sys); while (!arready);
    arvalid <= 0;
    do @(posedge clk_sys); while (!rvalid);
    resp = rresp;
    rready <= 0;
    chk(nm, e, rdata);
  endtask
  task automatic settle();
    repeat (300) @(posedge clk_sys);
  endtask
  task automatic results();
    $display("mismatches %0d of %0d compares", errorCnt, compares);
    if (errorCnt == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////
  // scenarios; each channel c converts to 0x1000*(c+1) in offset binary
  task automatic t_chan(logic sgn);
    formatSelectSwitch <= sgn;
    settle();
    for (int c = 0; c < 8; c++)
      rdc("chan", 8'(8 + 4 * c),
          32'(16'h1000 * (c + 1)) ^ {sgn, 15'h0});
    formatSelectSwitch <= 0;
    $display("channel values done");
  endtask
  task automatic t_range();
    logic [2:0] codes[6] = '{3'h2, 3'h6, 3'h0, 3'h1, 3'h4, 3'h5};
    foreach (codes[i]) begin
      rangeSwitch <= codes[i];
      settle();
      rdc("break", 8'h00, (codes[i] inside {3'h2, 3'h6}) ? 32'hAA : 0);
    end
    $display("range done");
  endtask
  task automatic t_limit();
    wr(8'h50, 32'h0800);
    wr(8'h44, 32'h2);
    settle();
    chk("leds", 8'h01, channelIndicators);
    rdc("limits", 8'h04, 32'h0100);
    wr(8'h44, 32'h0);
    settle();
    chk("leds off", 8'h00, channelIndicators);
    wr(8'h08, 32'h1);
    chk("scan write", ain_pkg::RESP_SLVERR, resp);
    rdc("unmapped", 8'hFC, 32'h0);
    chk("unmapped resp", ain_pkg::RESP_SLVERR, resp);
    $display("limits done");
  endtask
  task automatic t_skip();
    int n;
    wr(8'h48, 32'hFE);
    settle();
    n = 0;
    repeat (200) @(posedge clk_sys) n += int'(convStart && convChan != 0);
    chk("skipped starts", 0, n);
    rdc("kept", 8'h0C, 32'h2000);
    // ch0 scaled onto 0..0x4000: raw 0x1000 maps to a sixteenth of the span
    wr(8'h94, 32'h4000);
    chk("cdm resp", ain_pkg::RESP_OKAY, resp);
    wr(8'h8C, 32'h0100);
    settle();
    rdc("scaled", 8'h08, 32'h0400);
    $display("skip done");
  endtask
  task automatic t_blink();
    int n;
    logic prev;
    rangeSwitch <= 3'h7;
    settle();
    n = 0;
    prev = activityIndicator;
    for (int i = 0; i < 64; i++) begin
      @(posedge clk_sys);
      n += int'(activityIndicator !== prev);
      prev = activityIndicator;
    end
    chk("blinks", 1, n >= 4);
    // the host takes a blinking indicator as a fatal configuration error
    if (n >= 4) $display("host fault mode entered");
    $display("blink done");
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk_sys);
    srst <= 0;
    t_chan(0);
    rdc("flags", 8'h04, 32'h0);
    t_chan(1);
    t_range();
    t_limit();
    t_skip();
    t_blink();
    results();
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    errorCnt++;
    results();
  end
endmodule // eight_channel_analog_input_scan_bench
